// ---- fps_sequencer.sv ----
// fps_sequencer: four-rail power-on/off sequencer and supervisor.
// assumes comparator results arrive as async levels (1 = above threshold).
`timescale 1ns/100ps
module fps_sequencer
  import fps_pkg::*;
#(
  parameter bit OPEN_DRAIN = 1'b1,
  parameter int SEQ_DLY_CYCLES = fps_pkg::SEQ_DLY_CYC,
  parameter int PGT_CYCLES = fps_pkg::PGT_CYC,
  parameter int FAULT_HOLD_CYCLES = fps_pkg::FAULT_HOLD_CYC,
  parameter int POK_TIMEOUT_CYCLES = fps_pkg::POK_TIMEOUT_CYC
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_start_cmp,
  input wire logic i_stop_cmp,
  input wire logic i_undervoltage_sense_in,
  input wire logic [fps_pkg::NUM_RAILS-1:0] i_rail_monitor,
  input wire logic i_fault_line,
  output logic o_fault_line,
  output logic o_fault_line_oe,
  output logic [fps_pkg::NUM_RAILS-1:0] o_rail_enable,
  output logic [fps_pkg::NUM_RAILS-1:0] o_rail_enable_oe,
  output logic o_power_good_out,
  output logic o_power_good_out_oe,
  output logic o_done,
  output logic o_done_oe
);
  import fps_pkg::*;

  localparam logic [CNT_W-1:0] SEQ_LAST = CNT_W'(SEQ_DLY_CYCLES - 1);
  localparam logic [CNT_W-1:0] PGT_LAST = CNT_W'(PGT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(FAULT_HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] POK_LAST = CNT_W'(POK_TIMEOUT_CYCLES - 1);
  localparam int SYNC_W = NUM_RAILS + 4;

  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic [NUM_RAILS-1:0] mon_s;
  logic start_s;
  logic stop_s;
  logic uv_good_s;
  logic line_s;

  fps_state_t state_ff, nxt_state;
  logic [1:0] idx_ff, nxt_idx;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic [CNT_W-1:0] hold_ff, nxt_hold;
  logic hold_act_ff, nxt_hold_act;
  logic [NUM_RAILS-1:0] en_ff, nxt_en;
  logic done_ff, nxt_done;
  logic pok_ff, nxt_pok;
  logic start_d_ff, nxt_start_d;
  logic stop_d_ff, nxt_stop_d;
  logic pull_ff, nxt_pull;

  logic start_rise;
  logic stop_fall;
  logic ext_fault;
  logic int_fault;

  assign sync_in = {i_rail_monitor, i_start_cmp, i_stop_cmp, i_undervoltage_sense_in,
                    i_fault_line};

  fps_sync #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_async(sync_in),
    .o_sync(sync_out)
  );

  // a monitor strapped to the internal supply simply reads high
  assign mon_s = sync_out[SYNC_W-1:4];
  assign start_s = sync_out[3];
  assign stop_s = sync_out[2];
  assign uv_good_s = sync_out[1];
  assign line_s = sync_out[0];

  assign start_rise = start_s & ~start_d_ff;
  assign stop_fall = ~stop_s & stop_d_ff;
  // own pull reads back low, so only a low seen while released is foreign
  assign ext_fault = ~line_s & ~pull_ff;

  // sequencer next state
  always_comb begin
    nxt_state = state_ff;
    nxt_idx = idx_ff;
    nxt_cnt = cnt_ff;
    nxt_en = en_ff;
    nxt_done = done_ff;
    nxt_start_d = start_s;
    nxt_stop_d = stop_s;
    int_fault = 1'b0;
    case (state_ff)
      FPS_INIT: begin
        nxt_en = '0;
        // power-on starts with rail 1 after one delay
        if (start_rise && uv_good_s) begin
          nxt_done = 1'b0; // a new power-on clears a done left over from power-off
          nxt_state = FPS_UP_DLY;
          nxt_idx = FIRST_RAIL;
          nxt_cnt = '0;
        end
      end
      FPS_UP_DLY: begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (cnt_ff >= SEQ_LAST) begin
          nxt_en[idx_ff] = 1'b1;
          nxt_state = FPS_UP_WAIT;
          nxt_cnt = '0;
        end
      end
      FPS_UP_WAIT: begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        // next rail one delay after this monitor rises
        if (mon_s[idx_ff]) begin
          nxt_cnt = '0;
          if (idx_ff == LAST_RAIL) begin
            // done after the last rail is good
            nxt_done = 1'b1;
            nxt_state = FPS_ON;
          end else begin
            nxt_idx = idx_ff + 2'h1;
            nxt_state = FPS_UP_DLY;
          end
        // rail never came good in its window
        end else if (cnt_ff >= PGT_LAST) begin
          int_fault = 1'b1;
        end
      end
      FPS_ON: begin
        if (cnt_ff < POK_LAST) begin
          nxt_cnt = cnt_ff + CNT_W'(1);
        end
        // a rail dropping while fully on is a supervisory fault
        if (mon_s != '1) begin
          int_fault = 1'b1;
        end
      end
      FPS_DN_DLY: begin
        nxt_cnt = cnt_ff + CNT_W'(1);
        if (cnt_ff >= SEQ_LAST) begin
          nxt_en[idx_ff] = 1'b0;
          nxt_cnt = '0;
          nxt_state = (idx_ff == FIRST_RAIL) ? FPS_INIT : FPS_DN_WAIT;
        end
      end
      FPS_DN_WAIT: begin
        // lower rail drops one delay after the higher monitor falls
        if (!mon_s[idx_ff]) begin
          nxt_idx = idx_ff - 2'h1;
          nxt_cnt = '0;
          nxt_state = FPS_DN_DLY;
        end
      end
      default: begin
        nxt_state = FPS_INIT;
      end
    endcase
    // done holds through power-off, into init, until monitor 1 falls
    // rail 1 drops before its monitor does, so init must not clear done itself
    if ((state_ff == FPS_DN_DLY || state_ff == FPS_DN_WAIT || state_ff == FPS_INIT) &&
        !mon_s[0]) begin
      nxt_done = 1'b0;
    end
    // stop falling: rail 4 drops first, after one delay
    if (stop_fall && (state_ff == FPS_UP_DLY || state_ff == FPS_UP_WAIT ||
                      state_ff == FPS_ON)) begin
      nxt_state = FPS_DN_DLY;
      nxt_idx = LAST_RAIL;
      nxt_cnt = '0;
    end
    // undervoltage while rails are up is a fault too
    if (!uv_good_s && state_ff != FPS_INIT) begin
      int_fault = 1'b1;
    end
    // faults cut every enable at once and return to init
    if (int_fault || ext_fault) begin
      nxt_en = '0;
      nxt_done = 1'b0;
      nxt_cnt = '0;
      nxt_state = FPS_INIT;
    end
  end

  // power-good only after the timeout with all inputs good
  always_comb begin
    nxt_pok = (state_ff == FPS_ON) && (cnt_ff >= POK_LAST) && (mon_s == '1) &&
              uv_good_s && !ext_fault && !int_fault && !stop_fall;
  end

  // fault line: one-shot hold, stretched by undervoltage; an undervoltage fault holds only while it persists
  always_comb begin
    nxt_hold = hold_ff;
    nxt_hold_act = hold_act_ff;
    if (int_fault && !uv_good_s) begin
      nxt_hold_act = 1'b0;
    end else if (int_fault) begin
      nxt_hold_act = 1'b1;
      nxt_hold = '0;
    end else if (hold_act_ff) begin
      nxt_hold = hold_ff + CNT_W'(1);
      if (hold_ff >= HOLD_LAST) begin
        nxt_hold_act = 1'b0;
      end
    end
    nxt_pull = nxt_hold_act || (!uv_good_s && state_ff != FPS_INIT) ||
               (!uv_good_s && pull_ff);
  end

  // state registers
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      state_ff <= FPS_INIT;
      idx_ff <= 2'h0;
      cnt_ff <= '0;
      hold_ff <= '0;
      hold_act_ff <= 1'b0;
      en_ff <= '0;
      done_ff <= 1'b0;
      pok_ff <= 1'b0;
      start_d_ff <= 1'b1; // the synchroniser resets low, so a start held high at reset still gives an edge once it fills
      stop_d_ff <= 1'b0;
      pull_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      idx_ff <= nxt_idx;
      cnt_ff <= nxt_cnt;
      hold_ff <= nxt_hold;
      hold_act_ff <= nxt_hold_act;
      en_ff <= nxt_en;
      done_ff <= nxt_done;
      pok_ff <= nxt_pok;
      start_d_ff <= nxt_start_d;
      stop_d_ff <= nxt_stop_d;
      pull_ff <= nxt_pull;
    end
  end

  // fault line only ever pulled low
  assign o_fault_line = 1'b0;
  assign o_fault_line_oe = pull_ff;

  // open-drain releases when active, push-pull drives high
  assign o_rail_enable = OPEN_DRAIN ? '0 : en_ff;
  assign o_rail_enable_oe = OPEN_DRAIN ? ~en_ff : '1;
  assign o_power_good_out = OPEN_DRAIN ? 1'b0 : pok_ff;
  assign o_power_good_out_oe = OPEN_DRAIN ? ~pok_ff : 1'b1;
  assign o_done = OPEN_DRAIN ? 1'b0 : done_ff;
  assign o_done_oe = OPEN_DRAIN ? ~done_ff : 1'b1;
endmodule : fps_sequencer

// ---- fps_pkg.sv ----
// fps_pkg: constants shared by the four-rail power sequencer.
// assumes a single 100 MHz core clock; all times are in microseconds.
package fps_pkg;
  localparam int CLK_MHZ = 100;
  localparam int NUM_RAILS = 4;
  localparam int CNT_W = 16;
  // sequence delay between rails, typical open-pin value
  localparam int SEQ_DLY_US = 40;
  localparam int SEQ_DLY_CYC = SEQ_DLY_US * CLK_MHZ;
  // power-good window after a rail enable, typical open-pin value
  localparam int PGT_US = 5;
  localparam int PGT_CYC = PGT_US * CLK_MHZ;
  // fault line one-shot hold time, typical
  localparam int FAULT_HOLD_US = 80;
  localparam int FAULT_HOLD_CYC = FAULT_HOLD_US * CLK_MHZ;
  // reset timeout before power-good releases
  localparam int POK_TIMEOUT_US = 200;
  localparam int POK_TIMEOUT_CYC = POK_TIMEOUT_US * CLK_MHZ;
  localparam logic [1:0] LAST_RAIL = 2'h3;
  localparam logic [1:0] FIRST_RAIL = 2'h0;

  typedef enum logic [2:0] {
    FPS_INIT,
    FPS_UP_DLY,
    FPS_UP_WAIT,
    FPS_ON,
    FPS_DN_DLY,
    FPS_DN_WAIT
  } fps_state_t;
endpackage : fps_pkg

// ---- fps_sync.sv ----
// fps_sync: two-flop synchroniser for a vector of asynchronous levels.
// assumes each bit is an independent level; no bus coherency is kept.
`timescale 1ns/100ps
module fps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // first stage is read only by the second
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= i_async;
      sync_ff <= meta_ff;
    end
  end

  assign o_sync = sync_ff;
endmodule : fps_sync

// ---- fps_seq_checker.sv ----
// fps_seq_checker: port-level checks on the sequencer.
// assumes the push-pull variant, so enable data is the enable state.
`timescale 1ns/100ps
module fps_seq_checker #(
  parameter int SEQ_DLY_CYCLES = 8,
  parameter int POK_TIMEOUT_CYCLES = 12
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_start_cmp,
  input wire logic i_undervoltage_sense_in,
  input wire logic [3:0] i_rail_monitor,
  input wire logic i_fault_line,
  input wire logic o_fault_line,
  input wire logic o_fault_line_oe,
  input wire logic [3:0] o_rail_enable,
  input wire logic o_power_good_out,
  input wire logic o_done
);
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_srst);
  // rail steps: each enable needs its cause a full delay earlier
  en1_after_start_a: assert property ($rose(o_rail_enable[0]) |->
    $past(i_start_cmp, SEQ_DLY_CYCLES)) else $error("rail 1 enabled early");
  en2_after_mon_a: assert property ($rose(o_rail_enable[1]) |->
    $past(i_rail_monitor[0], SEQ_DLY_CYCLES)) else $error("rail 2 enabled early");
  en3_after_mon_a: assert property ($rose(o_rail_enable[2]) |->
    $past(i_rail_monitor[1], SEQ_DLY_CYCLES)) else $error("rail 3 enabled early");
  en4_after_mon_a: assert property ($rose(o_rail_enable[3]) |->
    $past(i_rail_monitor[2], SEQ_DLY_CYCLES)) else $error("rail 4 enabled early");
  rail_order_a: assert property (o_rail_enable inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("rails out of order");
  pok_release_a: assert property ($rose(o_power_good_out) |-> o_done &&
    $past(i_rail_monitor[3], POK_TIMEOUT_CYCLES)) else $error("power good early");
  pok_low_mon_a: assert property ((!(&i_rail_monitor) || !i_undervoltage_sense_in)[*5]
    |-> !o_power_good_out) else $error("power good with low supply");
  ext_fault_off_a: assert property ((!i_fault_line && !o_fault_line_oe)[*5]
    |-> !o_power_good_out && o_rail_enable == 4'h0) else $error("outside fault ignored");
  fault_shut_a: assert property ($rose(o_fault_line_oe) |->
    ##[0:1] (o_rail_enable == 4'h0 && !o_done)) else $error("fault left rails on");
  fault_hold_a: assert property ($rose(o_fault_line_oe) |-> o_fault_line_oe[*8])
    else $error("fault pull too short");
  fault_od_a: assert property (!o_fault_line) else $error("fault line driven high");
  cover property ($rose(o_power_good_out));
  cover property ($rose(o_fault_line_oe));
  cover property ($fell(o_done));
endmodule : fps_seq_checker

bind fps_sequencer fps_seq_checker #(.SEQ_DLY_CYCLES(SEQ_DLY_CYCLES),
  .POK_TIMEOUT_CYCLES(POK_TIMEOUT_CYCLES)) fps_seq_checker_i (.i_core_clk(i_core_clk),
  .i_srst(i_srst), .i_start_cmp(i_start_cmp), .i_undervoltage_sense_in(i_undervoltage_sense_in),
  .i_rail_monitor(i_rail_monitor), .i_fault_line(i_fault_line), .o_fault_line(o_fault_line),
  .o_fault_line_oe(o_fault_line_oe), .o_rail_enable(o_rail_enable),
  .o_power_good_out(o_power_good_out), .o_done(o_done));

// ---- fps_rails.sv ----
// fps_rails: regulators and monitor dividers behind the four rails.
// assumes resolved enable levels; a set fail bit keeps that rail low.
`timescale 1ns/100ps
module fps_rails (
  input wire logic i_core_clk,
  input wire logic [3:0] i_en,
  input wire logic [3:0] i_fail,
  output logic [3:0] o_mon
);
  logic [3:0] ramp1_ff;
  logic [3:0] ramp2_ff;
  always_ff @(posedge i_core_clk) begin
    ramp1_ff <= i_en & ~i_fail;
    ramp2_ff <= ramp1_ff;
  end
  assign o_mon = ramp2_ff & ~i_fail; // a failed rail drops at once
endmodule : fps_rails

// ---- tb_top.sv ----
// tb_top: self-checking bench for the four-rail sequencer.
// assumes push-pull outputs, shortened counts and a pulled-up fault wire.
`timescale 1ns/100ps
module tb_top;
  localparam int SEQ = 8;
  logic clk, srst, start, stop, uv, ext_pull, f_oe, f_d, power_good_out, pok_oe, done, done_oe;
  logic [3:0] fail, mon, en_d, en_oe, en_w;
  logic [6:0] st;
  logic fault_w;
  int error_cnt, n_tests;
  // wire resolution: released pins float high
  assign en_w = (en_d & en_oe) | ~en_oe;
  assign fault_w = (f_oe ? f_d : 1'h1) & ~ext_pull;
  assign st = {f_oe, done, power_good_out, en_w};
  fps_sequencer #(.OPEN_DRAIN(1'h0), .SEQ_DLY_CYCLES(SEQ), .PGT_CYCLES(20),
    .FAULT_HOLD_CYCLES(10), .POK_TIMEOUT_CYCLES(12)) fps_sequencer_i (.i_core_clk(clk),
    .i_srst(srst), .i_start_cmp(start), .i_stop_cmp(stop), .i_undervoltage_sense_in(uv),
    .i_rail_monitor(mon), .i_fault_line(fault_w), .o_fault_line(f_d), .o_fault_line_oe(f_oe),
    .o_rail_enable(en_d), .o_rail_enable_oe(en_oe), .o_power_good_out(power_good_out),
    .o_power_good_out_oe(pok_oe), .o_done(done), .o_done_oe(done_oe));
  fps_rails fps_rails_i (.i_core_clk(clk), .i_en(en_w), .i_fail(fail), .o_mon(mon));
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // bounded wait on masked outputs, cycles spent returned
  task automatic wait_st(input logic [6:0] mask, input logic [6:0] exp, output int cyc);
    cyc = 0;
    while ((st & mask) !== exp && cyc < 300) begin
      @(posedge clk);
      cyc++;
    end
    if ((st & mask) !== exp) begin
      error_cnt++;
      finish_test();
    end
  endtask : wait_st
  task automatic t_up;
    int c;
    start <= 1'h1; // rising start
    for (int k = 1; k <= 4; k++) begin
      wait_st(7'h0F, 7'((1 << k) - 1), c);
      check(8'(c >= SEQ && c <= SEQ + 8), 8'h01);
    end
    wait_st(7'h10, 7'h10, c);
    check(8'(c >= 12 && c <= 20), 8'h01);
    check(8'(done), 8'h01);
    check(8'({pok_oe, done_oe, en_oe}), 8'h3F);
    $display("power-up finished");
  endtask : t_up
  task automatic t_down;
    int c;
    stop <= 1'h0; // falling stop
    for (int k = 3; k >= 0; k--) begin
      wait_st(7'h0F, 7'((1 << k) - 1), c);
      check(8'(c >= SEQ && c <= SEQ + 8), 8'h01);
    end
    check(8'(st[5:4]), 8'h02);
    wait_st(7'h20, 7'h00, c);
    check(8'(c >= 4 && c <= 8), 8'h01);
    stop <= 1'h1;
    start <= 1'h0;
    // let the low start reach the edge detector before the next scenario
    repeat (4) @(posedge clk);
    $display("power-down finished");
  endtask : t_down
  // faults: recover, then let the line settle before the next start
  task automatic recover;
    int c;
    wait_st(7'h40, 7'h00, c);
    fail <= 4'h0;
    ext_pull <= 1'h0;
    start <= 1'h0;
    uv <= 1'h1;
    repeat (4) @(posedge clk);
  endtask : recover
  task automatic t_uv;
    uv <= 1'h0;
    start <= 1'h1;
    repeat (40) @(posedge clk);
    check(8'(en_w), 8'h00);
    recover();
    $display("undervoltage block finished");
  endtask : t_uv
  task automatic t_pgt;
    int c;
    fail <= 4'h2;
    start <= 1'h1;
    wait_st(7'h40, 7'h40, c);
    check(8'(c >= 2 * SEQ + 20 && c <= 2 * SEQ + 36), 8'h01);
    check(8'(st[5:0]), 8'h00);
    recover();
    $display("power-good timer finished");
  endtask : t_pgt
  task automatic t_ext;
    int c;
    t_up();
    ext_pull <= 1'h1;
    wait_st(7'h0F, 7'h00, c);
    check(8'(c <= 6), 8'h01);
    check(8'({f_oe, power_good_out}), 8'h00);
    recover();
    t_up();
    fail <= 4'h4;
    wait_st(7'h10, 7'h00, c);
    check(8'(c <= 6), 8'h01);
    wait_st(7'h0F, 7'h00, c);
    check(8'(c <= 6), 8'h01);
    check(8'(f_oe), 8'h01);
    recover();
    $display("fault shutdown finished");
  endtask : t_ext
  initial begin
    srst = 1'h1;
    start = 1'h0;
    stop = 1'h1;
    uv = 1'h1;
    ext_pull = 1'h0;
    fail = 4'h0;
    error_cnt = 0;
    n_tests = 0;
    repeat (4) @(posedge clk);
    srst <= 1'h0;
    @(posedge clk);
    t_up();
    t_down();
    t_uv();
    t_pgt();
    t_ext();
    finish_test();
  end
endmodule : tb_top
